/* File: csel_defs.svh */
/*
  Constants of the clock source selector: register offsets, field
  positions, reset values and timing figures.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef CSEL_DEFS_SVH
`define CSEL_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define CSEL_ADDR_W 8
`define CSEL_OFS_CTRL 8'h00
`define CSEL_OFS_STAT 8'h04
`define CSEL_OFS_IRQ_ST 8'h08
`define CSEL_OFS_IRQ_MSK 8'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSEL_CTRL_CHOICE_LSB 0
`define CSEL_CTRL_IFREQ_LSB 2
`define CSEL_CTRL_TWO_SPEED 6
`define CSEL_CTRL_CLOCK_FAIL_MONITOR_EN 7
`define CSEL_STAT_SRC_LSB 0
`define CSEL_STAT_OST_DONE 3
`define CSEL_STAT_FAIL 4
`define CSEL_STAT_MODE_LSB 5
`define CSEL_STAT_BOOTED 8
`define CSEL_IRQ_OST 0
`define CSEL_IRQ_FAIL 1
`define CSEL_IRQ_SWITCH 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CSEL_CTRL_RST 8'hfc
`define CSEL_IRQ_MSK_RST 3'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CSEL_CLK_PERIOD_NS 40
`define CSEL_OST_EDGES 1024
`define CSEL_CLOCK_FAIL_MONITOR_TIMEOUT_NS 100000

`endif

/* File: csel_pkg.sv */
/*
  Types of the clock source selector: oscillator modes, selected
  sources, sequencer states, and mode classification helpers.
  Assumes every user names items as csel_pkg::name.
*/
`default_nettype none

package csel_pkg;

  // Non-volatile oscillator mode codes
  typedef enum logic [2:0] {
    MODE_WATCH_XTAL = 3'b000,
    MODE_MID_XTAL = 3'b001,
    MODE_HIGH_XTAL = 3'b010,
    MODE_RES_CAP = 3'b011,
    MODE_INT_OSC = 3'b100,
    MODE_EXT_LOW = 3'b101,
    MODE_EXT_MID = 3'b110,
    MODE_EXT_HIGH = 3'b111
  } csel_mode_t;

  // System clock source picked by the selector
  typedef enum logic [2:0] {
    SRC_FAST = 3'b000,
    SRC_HF = 3'b001,
    SRC_LF = 3'b010,
    SRC_PRI = 3'b011,
    SRC_SEC = 3'b100
  } csel_src_t;

  // Start-up sequencer
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_OST_WAIT = 2'b01,
    ST_RUN = 2'b10,
    ST_SLEEP = 2'b11
  } csel_state_t;

  // Crystal or resonator modes need the start-up timer
  function automatic logic is_crystal(input csel_mode_t m);
    is_crystal = (m == MODE_WATCH_XTAL) || (m == MODE_MID_XTAL) ||
                 (m == MODE_HIGH_XTAL);
  endfunction

  // Logic-level external clock modes
  function automatic logic is_ext_clk(input csel_mode_t m);
    is_ext_clk = (m == MODE_EXT_LOW) || (m == MODE_EXT_MID) ||
                 (m == MODE_EXT_HIGH);
  endfunction

endpackage

`default_nettype wire

/* File: csel_mon_if.sv */
/*
  Signals between the selector and its start-up timer and monitor.
  Assumes all ends run on the one system clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface csel_mon_if;
  logic osc_edge;
  logic ost_start;
  logic ost_done;
  logic mon_en;
  logic fail;
  logic fail_clr;

  modport top (output osc_edge, output ost_start, output mon_en,
               output fail_clr, input ost_done, input fail);
  modport ost (input osc_edge, input ost_start, output ost_done);
  modport clock_fail_monitor (input osc_edge, input mon_en, input fail_clr,
                output fail);
endinterface

`default_nettype wire

/* File: csel_ost.sv */
/*
  Crystal start-up timer: counts oscillator edges after a start pulse.
  Assumes osc_edge is a one-cycle pulse per filtered rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csel_defs.svh"

module csel_ost #(
  parameter int unsigned EDGES = `CSEL_OST_EDGES
) (
  input wire logic clock,
  input wire logic nrst,
  csel_mon_if.ost mon
);

  localparam logic [10:0] LAST = 11'(EDGES - 1);

  logic [10:0] cnt_q;
  logic busy_q;
  logic done_q;

  // ----------------------------------------------------------------
  // Edge counter
  // ----------------------------------------------------------------
  // A new start always restarts the count from zero
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= 11'h000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (mon.ost_start)
    begin
      cnt_q <= 11'h000;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end
    else if (busy_q && mon.osc_edge)
    begin
      if (cnt_q == LAST)
      begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q + 11'h001;
      end
    end
  end

  assign mon.ost_done = done_q;

  ost_edge_count_a:
  assert property (@(posedge clock) disable iff (!nrst)
    $rose(done_q) |-> $past(mon.osc_edge) && $past(cnt_q) == LAST)
  else $error("start-up timer done without full edge count");

endmodule // csel_ost

`default_nettype wire

/* File: csel_clock_fail_monitor.sv */
/*
  Fail monitor: flags loss of the primary oscillator edges.
  Assumes osc_edge pulses once per edge and mon_en is from flops.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csel_defs.svh"

module csel_clock_fail_monitor #(
  parameter int unsigned TIMEOUT =
    (`CSEL_CLOCK_FAIL_MONITOR_TIMEOUT_NS + `CSEL_CLK_PERIOD_NS - 1) /
    `CSEL_CLK_PERIOD_NS
) (
  input wire logic clock,
  input wire logic nrst,
  csel_mon_if.clock_fail_monitor mon
);

  localparam logic [11:0] LIMIT = 12'(TIMEOUT - 1);

  logic [11:0] cnt_q;
  logic fail_q;

  // ----------------------------------------------------------------
  // Edge gap counter
  // ----------------------------------------------------------------
  // Saturates, so a dead source keeps the fault asserted
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cnt_q <= 12'h000;
    else if (!mon.mon_en || mon.osc_edge)
      cnt_q <= 12'h000;
    else if (cnt_q != LIMIT)
      cnt_q <= cnt_q + 12'h001;
  end

  // Sticky fault; detection wins over a clear in the same cycle
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      fail_q <= 1'b0;
    else if (mon.mon_en && !mon.osc_edge && cnt_q == LIMIT)
      fail_q <= 1'b1;
    else if (mon.fail_clr)
      fail_q <= 1'b0;
  end

  assign mon.fail = fail_q;

  fail_timeout_a:
  assert property (@(posedge clock) disable iff (!nrst)
    $rose(fail_q) |-> $past(cnt_q) == LIMIT && $past(mon.mon_en))
  else $error("fault raised before the edge gap timed out");

  edge_restart_a:
  assert property (@(posedge clock) disable iff (!nrst)
    mon.mon_en && mon.osc_edge |=> cnt_q == 12'h000 && !$rose(fail_q))
  else $error("edge did not restart the gap counter");

endmodule // csel_clock_fail_monitor

`default_nettype wire

/* File: csel_top.sv */
/*
  System clock source selector with APB registers, start-up
  sequencing, crystal start-up timer and fail monitor.
  Assumes the clock muxes and oscillators outside obey CLK_SEL and
  that OSC_MODE_CFG is stable from power-up.
*/
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "csel_defs.svh"

module csel_top (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [2:0] OSC_MODE_CFG,
  input wire logic PRIMARY_OSC_PIN,
  input wire logic HF_READY_PIN,
  input wire logic PWRT_DONE_PIN,
  input wire logic SLEEP_REQ,
  output logic [2:0] CLK_SEL,
  output logic [3:0] INT_FREQ_SEL,
  output logic [1:0] XTAL_GAIN,
  output logic EXEC_EN,
  output logic OSC_RETURN_FREE,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  csel_mon_if mon ();

  logic [2:0] s1_q, s2_q, s3_q, filt_q;
  logic pri_prev_q;
  logic cfg_taken_q;
  csel_pkg::csel_mode_t mode_q;
  csel_pkg::csel_state_t state_q, state_d;
  csel_pkg::csel_src_t clk_sel_q, clk_sel_d, run_src;
  logic exec_q, exec_d, start_d;
  logic [7:0] ctrl_q;
  logic [2:0] irq_st_q, irq_msk_q, irq_ev;
  logic ost_prev_q, fail_prev_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, irq_q;
  logic [1:0] gain_q;
  logic free_q;
  logic acc, fin, wr_ctrl, rd_irq, need_ost;
  logic [1:0] choice;
  logic [3:0] ifreq;
  logic two_speed, clock_fail_monitor_en, hf_rdy, pwrt_ok;

  assign choice = ctrl_q[`CSEL_CTRL_CHOICE_LSB +: 2];
  assign ifreq = ctrl_q[`CSEL_CTRL_IFREQ_LSB +: 4];
  assign two_speed = ctrl_q[`CSEL_CTRL_TWO_SPEED];
  assign clock_fail_monitor_en = ctrl_q[`CSEL_CTRL_CLOCK_FAIL_MONITOR_EN];
  assign hf_rdy = filt_q[1];
  assign pwrt_ok = filt_q[2];

  // Word-aligned hit on a register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // Internal block source for a frequency code; zero means 31 kHz
  function automatic csel_pkg::csel_src_t int_src(input logic [3:0] f);
    int_src = (f == 4'h0) ? csel_pkg::SRC_LF : csel_pkg::SRC_HF;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Three stages; a level is taken only once stages two and three agree
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      filt_q <= 3'h0;
      pri_prev_q <= 1'b0;
    end
    else
    begin
      s1_q <= {PWRT_DONE_PIN, HF_READY_PIN, PRIMARY_OSC_PIN};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (filt_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
      pri_prev_q <= filt_q[0];
    end
  end

  // Primary pin is sampled, so sources beyond a quarter of CLOCK alias
  assign mon.osc_edge = filt_q[0] & ~pri_prev_q;

  // ----------------------------------------------------------------
  // Mode strap capture
  // ----------------------------------------------------------------
  // Caught once after reset release; later strap changes wait for reset
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      cfg_taken_q <= 1'b0;
      mode_q <= csel_pkg::MODE_INT_OSC;
    end
    else if (!cfg_taken_q)
    begin
      cfg_taken_q <= 1'b1;
      mode_q <= csel_pkg::csel_mode_t'(OSC_MODE_CFG);
    end
  end

  // Pad setup follows the captured mode
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      gain_q <= 2'h0;
      free_q <= 1'b0;
    end
    else
    begin
      unique case (mode_q)
        csel_pkg::MODE_WATCH_XTAL: gain_q <= 2'h1;
        csel_pkg::MODE_MID_XTAL: gain_q <= 2'h2;
        csel_pkg::MODE_HIGH_XTAL: gain_q <= 2'h3;
        csel_pkg::MODE_RES_CAP, csel_pkg::MODE_INT_OSC,
        csel_pkg::MODE_EXT_LOW, csel_pkg::MODE_EXT_MID,
        csel_pkg::MODE_EXT_HIGH: gain_q <= 2'h0;
      endcase
      // Return pin only needed by the crystal amplifier
      free_q <= !csel_pkg::is_crystal(mode_q);
    end
  end

  // ----------------------------------------------------------------
  // Source choice while running
  // ----------------------------------------------------------------
  always_comb
  begin
    if (choice[1])
      run_src = int_src(ifreq);
    else if (mon.fail)
      run_src = csel_pkg::SRC_HF;
    else if (choice == 2'b01)
      run_src = csel_pkg::SRC_SEC;
    else if (mode_q == csel_pkg::MODE_INT_OSC)
      run_src = int_src(ifreq);
    else
      run_src = csel_pkg::SRC_PRI;
  end

  assign need_ost = (choice == 2'b00) && csel_pkg::is_crystal(mode_q) &&
                    !mon.ost_done && !mon.fail;

  // ----------------------------------------------------------------
  // Start-up sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    clk_sel_d = clk_sel_q;
    exec_d = 1'b0;
    start_d = 1'b0;
    unique case (state_q)
      csel_pkg::ST_BOOT:
      begin
        clk_sel_d = csel_pkg::SRC_FAST;
        if (cfg_taken_q && hf_rdy && pwrt_ok)
          state_d = csel_pkg::ST_RUN;
      end
      csel_pkg::ST_OST_WAIT:
      begin
        // Two-speed runs code on 16 MHz while the crystal settles
        exec_d = two_speed;
        clk_sel_d = two_speed ? csel_pkg::SRC_HF : csel_pkg::SRC_PRI;
        if (mon.ost_done || choice != 2'b00)
          state_d = csel_pkg::ST_RUN;
        else if (SLEEP_REQ)
          state_d = csel_pkg::ST_SLEEP;
      end
      csel_pkg::ST_RUN:
      begin
        exec_d = !SLEEP_REQ;
        clk_sel_d = run_src;
        if (SLEEP_REQ)
          state_d = csel_pkg::ST_SLEEP;
        else if (need_ost)
        begin
          // Leaving run for the wait must not let code slip one cycle
          state_d = csel_pkg::ST_OST_WAIT;
          start_d = 1'b1;
          exec_d = two_speed;
          clk_sel_d = two_speed ? csel_pkg::SRC_HF : csel_pkg::SRC_PRI;
        end
      end
      csel_pkg::ST_SLEEP:
      begin
        if (!SLEEP_REQ)
        begin
          // Wake restarts the count for crystals only
          if (csel_pkg::is_crystal(mode_q) && choice == 2'b00 &&
              !mon.fail)
          begin
            state_d = csel_pkg::ST_OST_WAIT;
            start_d = 1'b1;
          end
          else
            state_d = csel_pkg::ST_RUN;
        end
      end
    endcase
  end

  // Every state lives in flops on CLOCK; no clock means no change
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_q <= csel_pkg::ST_BOOT;
      clk_sel_q <= csel_pkg::SRC_FAST;
      exec_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      clk_sel_q <= clk_sel_d;
      exec_q <= exec_d;
    end
  end

  assign mon.ost_start = start_d;
  assign mon.mon_en = (state_q == csel_pkg::ST_RUN) && clock_fail_monitor_en &&
                      (clk_sel_q == csel_pkg::SRC_PRI) &&
                      (mode_q != csel_pkg::MODE_INT_OSC);

  csel_ost u_ost (
    .clock(CLOCK),
    .nrst(NRST),
    .mon(mon)
  );

  csel_clock_fail_monitor u_clock_fail_monitor (
    .clock(CLOCK),
    .nrst(NRST),
    .mon(mon)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state: PREADY rises in the second access cycle
  assign acc = PSEL && PENABLE && !pready_q;
  assign fin = PSEL && PENABLE && pready_q;
  assign wr_ctrl = fin && PWRITE && hit(PADDR, `CSEL_OFS_CTRL);
  assign rd_irq = fin && !PWRITE && hit(PADDR, `CSEL_OFS_IRQ_ST);
  assign mon.fail_clr = wr_ctrl;

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= acc;
      if (acc)
      begin
        pslverr_q <= !(hit(PADDR, `CSEL_OFS_CTRL) ||
                       hit(PADDR, `CSEL_OFS_STAT) ||
                       hit(PADDR, `CSEL_OFS_IRQ_ST) ||
                       hit(PADDR, `CSEL_OFS_IRQ_MSK));
        if (hit(PADDR, `CSEL_OFS_CTRL))
          prdata_q <= {24'h000000, ctrl_q};
        else if (hit(PADDR, `CSEL_OFS_STAT))
          prdata_q <= {23'h000000, state_q != csel_pkg::ST_BOOT,
                       mode_q, mon.fail, mon.ost_done, clk_sel_q};
        else if (hit(PADDR, `CSEL_OFS_IRQ_ST))
          prdata_q <= {29'h00000000, irq_st_q};
        else if (hit(PADDR, `CSEL_OFS_IRQ_MSK))
          prdata_q <= {29'h00000000, irq_msk_q};
        else
          prdata_q <= 32'h0000_0000;
      end
      else
      begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // Control and mask take effect at once, without a reset
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      ctrl_q <= `CSEL_CTRL_RST;
      irq_msk_q <= `CSEL_IRQ_MSK_RST;
    end
    else if (fin && PWRITE)
    begin
      if (hit(PADDR, `CSEL_OFS_CTRL))
        ctrl_q <= PWDATA[7:0];
      if (hit(PADDR, `CSEL_OFS_IRQ_MSK))
        irq_msk_q <= PWDATA[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_ev[`CSEL_IRQ_OST] = mon.ost_done && !ost_prev_q;
  assign irq_ev[`CSEL_IRQ_FAIL] = mon.fail && !fail_prev_q;
  assign irq_ev[`CSEL_IRQ_SWITCH] = clk_sel_d != clk_sel_q;

  // Read clears; an event in the clearing cycle still lands
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      irq_st_q <= 3'h0;
      ost_prev_q <= 1'b0;
      fail_prev_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_st_q <= (rd_irq ? 3'h0 : irq_st_q) | irq_ev;
      ost_prev_q <= mon.ost_done;
      fail_prev_q <= mon.fail;
      irq_q <= |(irq_st_q & irq_msk_q);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign CLK_SEL = clk_sel_q;
  assign INT_FREQ_SEL = ifreq;
  assign XTAL_GAIN = gain_q;
  assign EXEC_EN = exec_q;
  assign OSC_RETURN_FREE = free_q;
  assign IRQ = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  mode_hold_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    cfg_taken_q |=> $stable(mode_q) && cfg_taken_q)
  else $error("captured mode changed without reset");

  ext_no_timer_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    cfg_taken_q && csel_pkg::is_ext_clk(mode_q) |-> !mon.ost_start)
  else $error("start-up timer started in external clock mode");

  boot_fast_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    state_q == csel_pkg::ST_BOOT |=> clk_sel_q == csel_pkg::SRC_FAST
      || state_q == csel_pkg::ST_RUN)
  else $error("left fast start-up source during boot");

  int_choice_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    state_q == csel_pkg::ST_RUN && !SLEEP_REQ && choice[1]
      |=> clk_sel_q == csel_pkg::SRC_HF || clk_sel_q == csel_pkg::SRC_LF)
  else $error("internal choice did not select internal block");

  fail_switch_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    $rose(mon.fail) && state_q == csel_pkg::ST_RUN && !SLEEP_REQ &&
      !choice[1] |=> clk_sel_q == csel_pkg::SRC_HF)
  else $error("fault did not move clock to internal oscillator");

  timer_hold_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    state_q == csel_pkg::ST_OST_WAIT && !two_speed |=> !exec_q)
  else $error("execution ran during crystal start-up wait");

  two_speed_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    state_q == csel_pkg::ST_OST_WAIT && two_speed
      |=> exec_q && clk_sel_q == csel_pkg::SRC_HF)
  else $error("two-speed start-up not running on internal clock");

  sec_select_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    state_q == csel_pkg::ST_RUN && !SLEEP_REQ && choice == 2'b01 &&
      !mon.fail |=> clk_sel_q == csel_pkg::SRC_SEC)
  else $error("secondary oscillator not selected");

  pin_free_a:
  assert property (@(posedge CLOCK) disable iff (!NRST)
    cfg_taken_q && csel_pkg::is_ext_clk(mode_q) |=> ##1 OSC_RETURN_FREE)
  else $error("return pin not freed in external clock mode");

endmodule // csel_top

`default_nettype wire

/* File: csel_osc_model.sv */
/*
  Far-side model: crystal or external clock on the primary pin, plus
  ready flags of the internal oscillator and the power-up timer.
  Assumes a free-running system clock; run low stops the oscillator.
*/
`timescale 1ns/1ps
`default_nettype none

module csel_osc_model (
  input wire logic clk,
  input wire logic run,
  output logic osc,
  output logic hf_rdy,
  output logic pwrt_done,
  output int edges
);
  logic [7:0] age_q = 8'h00;
  logic [1:0] div_q = 2'h0;

  initial
  begin
    osc = 1'b0;
    hf_rdy = 1'b0;
    pwrt_done = 1'b0;
    edges = 0;
  end

  // Ready flags come late so the fast start-up phase is visible
  always @(posedge clk)
  begin
    if (age_q != 8'hff) age_q <= age_q + 8'h01;
    hf_rdy <= (age_q > 8'h1e);
    pwrt_done <= (age_q > 8'h28);
  end

  // Slow enough for the pin filter; a stopped part holds its level
  always @(posedge clk)
  begin
    if (run) div_q <= div_q + 2'h1;
    if (run && div_q == 2'h3)
    begin
      osc <= ~osc;
      if (!osc) edges <= edges + 1;
    end
  end
endmodule // csel_osc_model

`default_nettype wire

/* File: system_clock_source_selector_tb.sv */
/*
  Self-checking bench: APB tasks, source choices, fail switch-over,
  crystal start-up count and interrupts.
  Assumes csel_top and the oscillator model share one 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csel_defs.svh"

module system_clock_source_selector_tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] mode_cfg = 3'h7;
  logic sleep_req = 1'b0;
  logic run = 1'b1;
  logic osc, hf, pwrt, pready, pslverr, exec_en, ret_free, irq, er;
  logic [31:0] prdata, rd;
  logic [2:0] clk_sel;
  logic [3:0] ifreq;
  logic [1:0] gain;
  int edges, e0;
  int bad_count = 0;
  int samples_checked = 0;
  logic [7:0] cv [4] = '{8'hfd, 8'hfe, 8'hc2, 8'hfc};
  logic [2:0] sv [4] = '{3'h4, 3'h1, 3'h2, 3'h3};

  csel_top dut_u (.CLOCK(clock), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .OSC_MODE_CFG(mode_cfg), .PRIMARY_OSC_PIN(osc), .HF_READY_PIN(hf),
    .PWRT_DONE_PIN(pwrt), .SLEEP_REQ(sleep_req), .CLK_SEL(clk_sel),
    .INT_FREQ_SEL(ifreq), .XTAL_GAIN(gain), .EXEC_EN(exec_en),
    .OSC_RETURN_FREE(ret_free), .IRQ(irq));
  csel_osc_model osc_u (.clk(clock), .run(run), .osc(osc), .hf_rdy(hf),
    .pwrt_done(pwrt), .edges(edges));

  // 40 ns period
  initial forever #20 clock = ~clock;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One transfer; an idle edge after it keeps drivers from colliding
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      chk(32'h1, 32'h0);
      stop_test;
    end
    @(posedge clock);
  endtask

  // Bounded wait: 0 source, 1 execute enable, 2 interrupt
  task automatic wt(input int s, input logic [2:0] v, input int lim);
    int n;
    n = 0;
    while (n < lim && (s == 0 ? clk_sel : s == 1 ? {2'h0, exec_en} :
           {2'h0, irq}) !== v)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= lim)
    begin
      chk(32'h1, 32'h0);
      stop_test;
    end
  endtask

  task automatic rst(input logic [2:0] m);
    nrst <= 1'b0;
    mode_cfg <= m;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
  endtask

  // Main sequence
  initial
  begin
    rst(3'h7);
    chk(clk_sel, 32'h0);
    wt(1, 3'h1, 200);
    chk(clk_sel, 32'h3);
    chk({gain, ret_free}, 32'h1);
    apb(1'b0, `CSEL_OFS_STAT, 32'h0);
    chk(rd[7:5], 32'h7);
    apb(1'b0, `CSEL_OFS_CTRL, 32'h0);
    chk(rd, 32'hfc);
    apb(1'b0, `CSEL_OFS_IRQ_MSK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    // Strap moves mid-run; only the next reset may pick it up
    mode_cfg <= 3'h1;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, `CSEL_OFS_CTRL, {24'h0, cv[i]});
      wt(0, sv[i], 10);
      chk(ifreq, cv[i][5:2]);
    end
    apb(1'b0, `CSEL_OFS_STAT, 32'h0);
    chk({gain, rd[7:5]}, 32'h7);
    // Oscillator dies while it drives the system clock
    apb(1'b1, `CSEL_OFS_IRQ_MSK, 32'h2);
    run <= 1'b0;
    wt(0, 3'h1, 3000);
    wt(2, 3'h1, 5);
    apb(1'b0, `CSEL_OFS_IRQ_ST, 32'h0);
    chk(rd[1], 32'h1);
    wt(2, 3'h0, 5);
    run <= 1'b1;
    rst(3'h1);
    wt(1, 3'h1, 200);
    chk(clk_sel, 32'h1);
    chk({gain, ret_free}, 32'h4);
    wt(0, 3'h3, 10000);
    // Wake without two-speed: execution held for the full count
    apb(1'b1, `CSEL_OFS_CTRL, 32'hbc);
    apb(1'b1, `CSEL_OFS_IRQ_MSK, 32'h1);
    // First count's event is still pending; clear it so the next counts
    apb(1'b0, `CSEL_OFS_IRQ_ST, 32'h0);
    chk(rd[0], 32'h1);
    wt(2, 3'h0, 5);
    // Crystal stops in sleep, so no edge is in flight at wake
    sleep_req <= 1'b1;
    run <= 1'b0;
    wt(1, 3'h0, 5);
    repeat (8) @(posedge clock);
    sleep_req <= 1'b0;
    run <= 1'b1;
    e0 = edges;
    wt(1, 3'h1, 10000);
    chk(32'(edges - e0 >= 1024 && edges - e0 <= 1027), 32'h1);
    chk(clk_sel, 32'h3);
    wt(2, 3'h1, 5);
    stop_test;
  end
endmodule // system_clock_source_selector_tb

`default_nettype wire
